// File: rtl/audio_clock_synthesis.sv
// Audio clock generator: three audio clocks, frame sync and ten-field marker.
// Assumes a host register port on clk_sys_i and video timing pins from outside.
//
// What this block does
// - Select 000 disables clocks, 001-100 give 32/44.1/48/96k, 101-111 slow rates.
// - Slow rates only with 23.98/29.97/59.94 video; slow is nominal times 1000/1001.
// - Host override bit takes the rate from the host field, ignoring pins.
// - Effective select 000 puts all three clock outputs into high impedance.
// - After reset outputs run at 256, 64 and 1 times the sample rate.
// - Each output has a 3-bit multiple field at 3Fh; 111 is block-start flag.
// - 192fs and 384fs work only while allow-384 bit is high.
// - Block-start flag is high one sample period out of every 192.
// - The 1x sample clock has an exact 50 percent duty cycle.
// - At 96k with 192/384 in use or allow-384, 512fs has 33 percent duty.
// - First frame sync rising edge resets the phase accumulator, not the block-start counter, to align audio with video.
// - Dividers drift freely and are reset again when drift exceeds the window.
// - Window is bits 9-7 of 31h, default 010, doubling per code, 1XX widest.
// - Status 1Fh bit 1 shows audio PLL lock.
// - The 1x clock aligns with line 1 horizontal sync at the sequence start.
// - Sequence length follows samples per frame, e.g. five frames for 48k at 29.97.
// - Field-ID input active at line 1 sync resynchronises the frame sequence.
// - Without field-ID the block makes its own frame sync for the format.
// - Write to 1Ah resets frame sync and/or ten-field divider at next frame.
// - Audio control bit 0 stops field-ID from resetting the frame sync divider.
// - Allow-384 is bit 5 of 31h and resets low.
`timescale 1ns/1ns
module audio_clock_synthesis
  import audio_clock_synthesis_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic host_wr_i,
  input wire logic [7:0] host_addr_i,
  input wire logic [15:0] host_wdata_i,
  output logic [15:0] host_rdata_o,
  input wire logic [2:0] sample_rate_select_i,
  input wire logic host_rate_override_i,
  input wire logic [2:0] host_sample_rate_i,
  input wire logic field_id_ignore_i,
  input wire logic [2:0] video_frame_rate_i,
  input wire logic line1_hsync_i,
  input wire logic field_id_i,
  input wire logic audio_pll_lock_i,
  output logic audio_clock_out_first_o,
  output logic audio_clock_out_second_o,
  output logic audio_clock_out_third_o,
  output logic audio_clock_oe_o,
  output logic audio_frame_sync_pulse_o,
  output logic ten_field_marker_o
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [5:0] pin_meta_ff;
  logic [5:0] pin_sync_ff;
  logic [2:0] pin_sel;
  logic line1_sync;
  logic fid_sync;
  logic lock_sync;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pin_meta_ff <= 6'h00;
      pin_sync_ff <= 6'h00;
    end
    else
    begin
      pin_meta_ff <= {audio_pll_lock_i, field_id_i, line1_hsync_i, sample_rate_select_i};
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign pin_sel = pin_sync_ff[2:0];
  assign line1_sync = pin_sync_ff[3];
  assign fid_sync = pin_sync_ff[4];
  assign lock_sync = pin_sync_ff[5];

  // ---------------------------------------------------------------
  // Sample rate selection
  // ---------------------------------------------------------------
  logic [2:0] sel_eff;
  logic [2:0] sel_prev_ff;
  logic slow_sel;
  logic drop_rate;
  logic rate_on;
  logic sel_change;
  logic [31:0] inc;

  assign sel_eff = host_rate_override_i ? host_sample_rate_i : pin_sel;
  assign drop_rate = is_drop(video_frame_rate_i);
  assign slow_sel = sel_eff[2] && (sel_eff[1:0] != 2'h0);
  assign rate_on = (sel_eff != SEL_OFF) && !(slow_sel && !drop_rate);
  assign inc = rate_inc(sel_eff);
  assign sel_change = sel_eff != sel_prev_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sel_prev_ff <= SEL_OFF;
    else
      sel_prev_ff <= sel_eff;
  end

  // ---------------------------------------------------------------
  // Host registers
  // ---------------------------------------------------------------
  logic [15:0] window_ff;
  logic [15:0] mult_ff;
  logic [15:0] rdata_ff;
  logic [15:0] status_word;
  logic [2:0] win_code;
  logic allow;
  logic wr_resync;
  align_state_t align_ff;

  assign win_code = window_ff[WIN_LSB +: 3];
  assign allow = window_ff[ALLOW_BIT];
  assign wr_resync = host_wr_i && (host_addr_i == REG_RESYNC);

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      window_ff <= WINDOW_RST;
      mult_ff <= MULT_RST;
    end
    else if (host_wr_i)
    begin
      if (host_addr_i == REG_WINDOW)
        window_ff <= host_wdata_i & WINDOW_MASK;
      if (host_addr_i == REG_MULT)
        mult_ff <= host_wdata_i & MULT_MASK;
    end
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[LOCK_BIT] = lock_sync;
    status_word[ALIGN_BIT] = (align_ff == ALIGN_TRACK);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rdata_ff <= 16'h0000;
    else
    begin
      case (host_addr_i)
        REG_LOCK: rdata_ff <= status_word;
        REG_WINDOW: rdata_ff <= window_ff;
        REG_MULT: rdata_ff <= mult_ff;
        default: rdata_ff <= 16'h0000;
      endcase
    end
  end

  assign host_rdata_o = rdata_ff;

  // ---------------------------------------------------------------
  // Frame sequence and ten-field dividers
  // ---------------------------------------------------------------
  logic line_prev_ff;
  logic frame_edge;
  logic afs_pend_ff;
  logic ten_pend_ff;
  logic [7:0] seq;
  logic [7:0] afs_cnt_ff;
  logic [7:0] nxt_afs_cnt;
  logic [3:0] ten_len;
  logic [3:0] ten_cnt_ff;
  logic [3:0] nxt_ten_cnt;
  logic afs_restart;
  logic ten_restart;
  logic afs_evt;
  logic ten_evt;
  logic afs_ff;
  logic ten_ff;

  assign frame_edge = line1_sync && !line_prev_ff;
  assign seq = seq_len(sel_eff, video_frame_rate_i);
  assign ten_len = (video_frame_rate_i == FR_2997 || video_frame_rate_i == FR_30) ? TEN_SHORT : TEN_LONG;
  assign afs_restart = frame_edge && ((fid_sync && !field_id_ignore_i) || afs_pend_ff);
  assign ten_restart = frame_edge && (fid_sync || ten_pend_ff);

  always_comb
  begin
    nxt_afs_cnt = afs_cnt_ff;
    if (afs_restart)
      nxt_afs_cnt = 8'h00;
    else if (frame_edge)
      nxt_afs_cnt = (afs_cnt_ff + 8'h01 >= seq) ? 8'h00 : afs_cnt_ff + 8'h01;
  end

  always_comb
  begin
    nxt_ten_cnt = ten_cnt_ff;
    if (ten_restart)
      nxt_ten_cnt = 4'h0;
    else if (frame_edge)
      nxt_ten_cnt = (ten_cnt_ff + 4'h1 >= ten_len) ? 4'h0 : ten_cnt_ff + 4'h1;
  end

  assign afs_evt = frame_edge && (nxt_afs_cnt == 8'h00);
  assign ten_evt = frame_edge && (nxt_ten_cnt == 4'h0);

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      line_prev_ff <= 1'b0;
      afs_pend_ff <= 1'b0;
      ten_pend_ff <= 1'b0;
      afs_cnt_ff <= 8'h00;
      ten_cnt_ff <= 4'h0;
      afs_ff <= 1'b0;
      ten_ff <= 1'b0;
    end
    else
    begin
      line_prev_ff <= line1_sync;
      // New request wins over consumption at a frame edge
      afs_pend_ff <= (wr_resync && host_wdata_i[RESYNC_AFS_BIT]) || (afs_pend_ff && !frame_edge);
      ten_pend_ff <= (wr_resync && host_wdata_i[RESYNC_TEN_BIT]) || (ten_pend_ff && !frame_edge);
      afs_cnt_ff <= nxt_afs_cnt;
      ten_cnt_ff <= nxt_ten_cnt;
      afs_ff <= afs_evt || (afs_ff && line1_sync);
      ten_ff <= ten_evt || (ten_ff && line1_sync);
    end
  end

  assign audio_frame_sync_pulse_o = afs_ff;
  assign ten_field_marker_o = ten_ff;

  // ---------------------------------------------------------------
  // Sample phase accumulator and alignment
  // ---------------------------------------------------------------
  logic [31:0] acc_ff;
  logic [32:0] acc_sum;
  logic [31:0] acc_adv;
  logic [31:0] err;
  logic [2:0] shift;
  logic [39:0] thr;
  logic drift_big;
  logic realign;
  logic wrap;
  align_state_t nxt_align;

  assign acc_sum = {1'b0, acc_ff} + {1'b0, inc};
  assign acc_adv = acc_sum[31:0];
  assign wrap = acc_sum[32];
  assign err = acc_ff[31] ? (32'h0 - acc_ff) : acc_ff;
  assign shift = win_code[2] ? 3'h4 : {1'b0, win_code[1:0]};
  assign thr = ({8'h00, inc} * 40'(WIN_MIN_CYC)) << shift;
  assign drift_big = {8'h00, err} > thr;
  assign realign = afs_evt && rate_on && ((align_ff == ALIGN_WAIT) || drift_big);

  always_comb
  begin
    nxt_align = align_ff;
    case (align_ff)
      ALIGN_WAIT:
        if (realign)
          nxt_align = ALIGN_TRACK;
      ALIGN_TRACK:
        if (sel_change || !rate_on)
          nxt_align = ALIGN_WAIT;
      default: nxt_align = ALIGN_WAIT;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      align_ff <= ALIGN_WAIT;
      acc_ff <= 32'h0;
    end
    else
    begin
      align_ff <= nxt_align;
      acc_ff <= (!rate_on || realign) ? 32'h0 : acc_adv;
    end
  end

  // ---------------------------------------------------------------
  // Block-start counter and clock outputs
  // ---------------------------------------------------------------
  logic [7:0] zbit_cnt_ff;
  logic zbit;
  logic [31:0] p3;
  logic any_high;
  logic third_mode;
  logic [2:0] nxt_aclk;
  logic [2:0] aclk_ff;
  logic oe_ff;
  logic fs_ref;

  function automatic logic aclk_bit(input logic [2:0] m, input logic [31:0] a, input logic [31:0] a3,
                                    input logic al, input logic th, input logic zb);
    case (m)
      MUL_FS: return ~a[31];
      MUL_64: return ~a[25];
      MUL_128: return ~a[24];
      MUL_192: return al && ~a3[25];
      MUL_256: return ~a[23];
      MUL_384: return al && ~a3[24];
      MUL_512: return th ? (a[22:0] < THIRD_PHASE) : ~a[22];
      default: return zb;
    endcase
  endfunction

  assign zbit = (zbit_cnt_ff == 8'h00);
  assign p3 = acc_ff + {acc_ff[30:0], 1'b0};
  assign fs_ref = ~acc_ff[31];

  always_comb
  begin
    any_high = 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      if (mult_ff[MULT_W*i +: MULT_W] == MUL_192 || mult_ff[MULT_W*i +: MULT_W] == MUL_384)
        any_high = 1'b1;
    end
  end

  assign third_mode = (sel_eff == SEL_96K) && (allow || any_high);

  always_comb
  begin
    nxt_aclk = 3'h0;
    for (int i = 0; i < 3; i++)
      nxt_aclk[i] = aclk_bit(mult_ff[MULT_W*i +: MULT_W], acc_ff, p3, allow, third_mode, zbit);
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      zbit_cnt_ff <= 8'h00;
    else if (wrap)
      zbit_cnt_ff <= (zbit_cnt_ff == ZBIT_LAST) ? 8'h00 : zbit_cnt_ff + 8'h01;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      aclk_ff <= 3'h0;
      oe_ff <= 1'b0;
    end
    else
    begin
      aclk_ff <= rate_on ? nxt_aclk : 3'h0;
      oe_ff <= rate_on;
    end
  end

  assign audio_clock_out_first_o = aclk_ff[0];
  assign audio_clock_out_second_o = aclk_ff[1];
  assign audio_clock_out_third_o = aclk_ff[2];
  assign audio_clock_oe_o = oe_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic first_ff;

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
      first_ff <= 1'b0;
    else
      first_ff <= 1'b1;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_disable_hiz:
    assert property (sel_eff == SEL_OFF |=> !audio_clock_oe_o)
    else $error("clocks driven while disabled");
  chk_slow_gate:
    assert property (slow_sel && !drop_rate |=> !audio_clock_oe_o)
    else $error("slow rate without drop-frame video");
  chk_override_src:
    assert property (host_rate_override_i && host_sample_rate_i == SEL_OFF |=> !audio_clock_oe_o)
    else $error("host rate override ignored");
  chk_reset_mults:
    assert property (!first_ff |-> mult_ff == MULT_RST)
    else $error("wrong output multiples after reset");
  chk_fs_duty:
    assert property (rate_on && mult_ff[2:0] == MUL_FS ##1 rate_on |-> audio_clock_out_first_o == $past(fs_ref))
    else $error("1x clock not half period");
  chk_gate_384:
    assert property (!allow && mult_ff[2:0] == MUL_192 |=> !audio_clock_out_first_o)
    else $error("192fs output without allow bit");
  chk_zbit_period:
    assert property (wrap && zbit_cnt_ff == ZBIT_LAST |=> zbit_cnt_ff == 8'h00 && zbit)
    else $error("block start period not 192");
  chk_start_align:
    assert property (afs_evt && rate_on && align_ff == ALIGN_WAIT |=> acc_ff == 32'h0 && align_ff == ALIGN_TRACK)
    else $error("dividers not reset on first frame sync");
  chk_drift_realign:
    assert property (afs_evt && rate_on && align_ff == ALIGN_TRACK && drift_big |=> acc_ff == 32'h0)
    else $error("drift beyond window not corrected");
  chk_drift_hold:
    assert property (afs_evt && rate_on && !sel_change && align_ff == ALIGN_TRACK && !drift_big
      |=> acc_ff == $past(acc_adv))
    else $error("realigned inside window");
  chk_lock_flag:
    assert property (lock_sync && host_addr_i == REG_LOCK |=> host_rdata_o[LOCK_BIT])
    else $error("lock status not shown");
  chk_host_resync:
    assert property (afs_pend_ff && frame_edge && !wr_resync |=> afs_cnt_ff == 8'h00 && !afs_pend_ff)
    else $error("host resync not applied at frame start");
  chk_fid_ignore:
    assert property (frame_edge && field_id_ignore_i && !afs_pend_ff && afs_cnt_ff + 8'h01 < seq
      |=> afs_cnt_ff == $past(afs_cnt_ff) + 8'h01)
    else $error("field-ID reset while ignored");

  cov_first_align: cover property (realign && align_ff == ALIGN_WAIT);
  cov_drift_fix: cover property (realign && align_ff == ALIGN_TRACK);
  cov_block_start: cover property (wrap && zbit_cnt_ff == ZBIT_LAST);
  cov_third_duty: cover property (third_mode && rate_on);
endmodule

// File: rtl/audio_clock_synthesis_pkg.sv
// Constants, register map and helper functions for the audio clock block.
// Assumes a 50 MHz system clock that stands in for the internal video clock.
package audio_clock_synthesis_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_RESYNC = 8'h1A;
  localparam logic [7:0] REG_LOCK = 8'h1F;
  localparam logic [7:0] REG_WINDOW = 8'h31;
  localparam logic [7:0] REG_MULT = 8'h3F;
  localparam logic [15:0] WINDOW_RST = 16'h0100;
  localparam logic [15:0] WINDOW_MASK = 16'h03A0;
  localparam logic [15:0] MULT_RST = 16'h000C;
  localparam logic [15:0] MULT_MASK = 16'h01FF;
  localparam int WIN_LSB = 32'h7;
  localparam int ALLOW_BIT = 32'h5;
  localparam int LOCK_BIT = 32'h1;
  localparam int ALIGN_BIT = 32'h0;
  localparam int RESYNC_AFS_BIT = 32'h0;
  localparam int RESYNC_TEN_BIT = 32'h1;
  localparam int MULT_W = 32'h3;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_96K = 3'h4;
  localparam logic [2:0] MUL_FS = 3'h0;
  localparam logic [2:0] MUL_64 = 3'h1;
  localparam logic [2:0] MUL_128 = 3'h2;
  localparam logic [2:0] MUL_192 = 3'h3;
  localparam logic [2:0] MUL_256 = 3'h4;
  localparam logic [2:0] MUL_384 = 3'h5;
  localparam logic [2:0] MUL_512 = 3'h6;
  localparam logic [2:0] FR_24 = 3'h0;
  localparam logic [2:0] FR_2997 = 3'h2;
  localparam logic [2:0] FR_30 = 3'h3;
  localparam logic [2:0] FR_5994 = 3'h5;
  localparam logic [2:0] FR_60 = 3'h6;
  localparam logic [2:0] FR_2398 = 3'h7;
  localparam logic [7:0] ZBIT_LAST = 8'hBF;
  localparam logic [3:0] TEN_SHORT = 4'h5;
  localparam logic [3:0] TEN_LONG = 4'hA;
  localparam logic [22:0] THIRD_PHASE = 23'h2AAAAB;
  // ---------------------------------------------------------------
  // Timing and phase increments
  // ---------------------------------------------------------------
  localparam int CLK_NS = 32'h14;
  localparam int WIN_MIN_NS = 32'h2C;
  localparam int WIN_MIN_CYC = (WIN_MIN_NS / CLK_NS) < 1 ? 1 : (WIN_MIN_NS / CLK_NS);
  localparam logic [63:0] CLK_HZ = 64'h2FAF080;
  localparam logic [63:0] TWO32 = 64'h100000000;
  localparam logic [63:0] SLOW_NUM = 64'h3E8;
  localparam logic [63:0] SLOW_DEN = 64'h3E9;
  localparam logic [31:0] INC_32K = 32'((64'h7D00 * TWO32) / CLK_HZ);
  localparam logic [31:0] INC_44K = 32'((64'hAC44 * TWO32) / CLK_HZ);
  localparam logic [31:0] INC_48K = 32'((64'hBB80 * TWO32) / CLK_HZ);
  localparam logic [31:0] INC_96K = 32'((64'h17700 * TWO32) / CLK_HZ);
  localparam logic [31:0] INC_S32K = 32'((64'h7D00 * SLOW_NUM * TWO32) / (SLOW_DEN * CLK_HZ));
  localparam logic [31:0] INC_S44K = 32'((64'hAC44 * SLOW_NUM * TWO32) / (SLOW_DEN * CLK_HZ));
  localparam logic [31:0] INC_S48K = 32'((64'hBB80 * SLOW_NUM * TWO32) / (SLOW_DEN * CLK_HZ));

  typedef enum logic {ALIGN_WAIT, ALIGN_TRACK} align_state_t;

  function automatic logic is_drop(input logic [2:0] fr);
    return (fr == FR_2997) || (fr == FR_5994) || (fr == FR_2398);
  endfunction

  function automatic logic [31:0] rate_inc(input logic [2:0] sel);
    case (sel)
      3'h1: return INC_32K;
      3'h2: return INC_44K;
      3'h3: return INC_48K;
      3'h4: return INC_96K;
      3'h5: return INC_S32K;
      3'h6: return INC_S44K;
      3'h7: return INC_S48K;
      default: return 32'h0;
    endcase
  endfunction

  // Frames per audio frame sequence
  function automatic logic [7:0] seq_len(input logic [2:0] sel, input logic [2:0] fr);
    case (sel)
      3'h1: return (fr == FR_2997 || fr == FR_5994) ? 8'h0F :
        (fr == FR_24 || fr == FR_30 || fr == FR_60 || fr == FR_2398) ? 8'h03 : 8'h01;
      3'h2: return (fr == FR_2997) ? 8'h64 : (fr == FR_5994) ? 8'hC8 :
        (fr == FR_2398) ? 8'h50 : (fr == FR_24) ? 8'h02 : 8'h01;
      3'h3, 3'h4: return (fr == FR_2997 || fr == FR_5994) ? 8'h05 : 8'h01;
      3'h5: return 8'h03;
      3'h6: return (fr == FR_2398) ? 8'h02 : 8'h01;
      default: return 8'h01;
    endcase
  endfunction
endpackage

// File: verif/audio_clock_consumer.sv
// Model of the audio gear: frame timing source and clock edge counter.
// Assumes the clock pins count only while the output enable is high.
`timescale 1ns/1ns
module audio_clock_consumer
#(
  parameter int FRAME = 3125
)
(
  input wire logic clk_sys_i,
  input wire logic clr_i,
  input wire logic [2:0] clk_pin_i,
  input wire logic oe_i,
  input wire logic fid_en_i,
  input wire logic [15:0] fid_frame_i,
  output logic line1_hsync_o,
  output logic field_id_o,
  output logic [15:0] frame_no_o,
  output logic [15:0] edges_o [3],
  output logic [15:0] high_o
);
  logic [15:0] phase_ff;
  logic [2:0] last_ff;

  initial
  begin
    phase_ff = 16'h0;
    last_ff = 3'h0;
    frame_no_o = 16'h0;
    line1_hsync_o = 1'b0;
    high_o = 16'h0;
    edges_o = '{16'h0, 16'h0, 16'h0};
  end

  // Field-ID only inside line 1 sync of the chosen frame, low otherwise
  assign field_id_o = line1_hsync_o & fid_en_i & (frame_no_o == fid_frame_i);

  always @(posedge clk_sys_i)
  begin
    phase_ff <= (phase_ff == 16'(FRAME - 1)) ? 16'h0 : phase_ff + 16'h1;
    if (phase_ff == 16'h0)
      frame_no_o <= frame_no_o + 16'h1;
    line1_hsync_o <= (phase_ff < 16'h32);
    last_ff <= clk_pin_i;
    for (int i = 0; i < 3; i++)
      edges_o[i] <= clr_i ? 16'h0 : edges_o[i] + 16'(oe_i & clk_pin_i[i] & ~last_ff[i]);
    high_o <= clr_i ? 16'h0 : high_o + 16'(oe_i & clk_pin_i[2]);
  end
endmodule

// File: verif/audio_clock_synthesis_tb_top.sv
// Self-checking bench for the audio clock block.
// Assumes a frame of 3125 cycles, a whole number of 32k and 48k periods.
`timescale 1ns/1ns
module audio_clock_synthesis_tb_top
  import audio_clock_synthesis_pkg::*;
();
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic host_wr_i = 1'b0;
  logic [7:0] host_addr_i = 8'h00;
  logic [15:0] host_wdata_i = 16'h0000;
  logic [2:0] sample_rate_select_i = 3'h1;
  logic host_rate_override_i = 1'b0;
  logic [2:0] host_sample_rate_i = 3'h0;
  logic field_id_ignore_i = 1'b0;
  logic [2:0] video_frame_rate_i = 3'h1;
  logic audio_pll_lock_i = 1'b0;
  logic fid_en = 1'b0;
  logic clr = 1'b0;
  logic [15:0] fid_frame = 16'h0;
  logic [15:0] host_rdata_o, frame_no, high_cnt, rd, f0;
  logic [15:0] afs_cnt = 16'h0, tfm_cnt = 16'h0;
  logic [15:0] edges [3];
  logic line1_hsync_i, field_id_i, oe, audio_frame_sync_pulse, tfm;
  logic afs_q = 1'b0, tfm_q = 1'b0;
  logic [2:0] aclk;
  int mul [7] = '{1, 64, 128, 192, 256, 384, 512};
  int fail_count = 0, checked = 0, cycles = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  audio_clock_synthesis DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .host_wr_i(host_wr_i),
    .host_addr_i(host_addr_i), .host_wdata_i(host_wdata_i), .host_rdata_o(host_rdata_o),
    .sample_rate_select_i(sample_rate_select_i), .host_rate_override_i(host_rate_override_i),
    .host_sample_rate_i(host_sample_rate_i), .field_id_ignore_i(field_id_ignore_i),
    .video_frame_rate_i(video_frame_rate_i), .line1_hsync_i(line1_hsync_i), .field_id_i(field_id_i),
    .audio_pll_lock_i(audio_pll_lock_i), .audio_clock_out_first_o(aclk[0]),
    .audio_clock_out_second_o(aclk[1]), .audio_clock_out_third_o(aclk[2]), .audio_clock_oe_o(oe),
    .audio_frame_sync_pulse_o(audio_frame_sync_pulse), .ten_field_marker_o(tfm));

  audio_clock_consumer #(.FRAME(3125)) partner (.clk_sys_i(clk_sys_i), .clr_i(clr), .clk_pin_i(aclk),
    .oe_i(oe), .fid_en_i(fid_en), .fid_frame_i(fid_frame), .line1_hsync_o(line1_hsync_i),
    .field_id_o(field_id_i), .frame_no_o(frame_no), .edges_o(edges), .high_o(high_cnt));

  always @(posedge clk_sys_i)
  begin
    afs_q <= audio_frame_sync_pulse;
    tfm_q <= tfm;
    afs_cnt <= clr ? 16'h0 : afs_cnt + 16'(audio_frame_sync_pulse & ~afs_q);
    tfm_cnt <= clr ? 16'h0 : tfm_cnt + 16'(tfm & ~tfm_q);
    cycles <= cycles + 1;
    if (cycles == 99000)
    begin
      fail_count++;
      results();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic near(input string name, input logic [15:0] seen, input logic [15:0] exp,
                      input logic [15:0] tol);
    if (seen + tol >= exp && seen <= exp + tol)
      check(name, exp, exp);
    else
      check(name, seen, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    host_wr_i <= 1'b1;
    host_addr_i <= a;
    host_wdata_i <= d;
    @(posedge clk_sys_i);
    host_wr_i <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    host_addr_i <= a;
    repeat (2) @(posedge clk_sys_i);
    #1 d = host_rdata_o;
  endtask

  task automatic measure(input int n);
    @(posedge clk_sys_i);
    clr <= 1'b1;
    @(posedge clk_sys_i);
    clr <= 1'b0;
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wait_afs(output logic [15:0] f);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_sys_i);
      #1 k++;
    end while (!(audio_frame_sync_pulse === 1'b1 && afs_q === 1'b0) && k < 20000);
    f = frame_no;
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd_reg(REG_WINDOW, rd);
    check("window reset", rd, 16'h0100);
    rd_reg(REG_MULT, rd);
    check("multiple reset", rd, 16'h000C);
    repeat (3125) @(posedge clk_sys_i);
    measure(3125);
    near("first at 256fs", edges[0], 16'd512, 16'd2);
    near("second at 64fs", edges[1], 16'd128, 16'd1);
    near("third at fs", edges[2], 16'd2, 16'd1);
    near("fs high time", high_cnt, 16'd1562, 16'd2);
    $display("reset test done");
    wr(REG_WINDOW, 16'hFFFF);
    rd_reg(REG_WINDOW, rd);
    check("window mask", rd, 16'h03A0);
    wr(REG_WINDOW, 16'h0000);
    wr(REG_LOCK, 16'h0000);
    rd_reg(REG_LOCK, rd);
    check("unlocked", rd & 16'h0002, 16'h0000);
    @(posedge clk_sys_i);
    audio_pll_lock_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    rd_reg(REG_LOCK, rd);
    check("locked", rd & 16'h0002, 16'h0002);
    wr(REG_WINDOW, 16'h0200);
    rd_reg(REG_WINDOW, rd);
    check("window widest", rd, 16'h0200);
    rd_reg(8'h50, rd);
    check("unmapped read", rd, 16'h0000);
    rd_reg(REG_RESYNC, rd);
    check("write only read", rd, 16'h0000);
    $display("register test done");
    for (int c = 0; c < 16; c++)
    begin
      @(posedge clk_sys_i);
      sample_rate_select_i <= 3'(c);
      video_frame_rate_i <= c[3] ? FR_2997 : 3'h1;
      repeat (8) @(posedge clk_sys_i);
      #1 check("oe by select", 16'(oe), 16'((c % 8 != 0) && (c % 8 < 5 || c > 7)));
    end
    @(posedge clk_sys_i);
    sample_rate_select_i <= SEL_OFF;
    host_rate_override_i <= 1'b1;
    host_sample_rate_i <= 3'h3;
    repeat (8) @(posedge clk_sys_i);
    #1 check("host rate override", 16'(oe), 16'h0001);
    $display("select test done");
    @(posedge clk_sys_i);
    host_rate_override_i <= 1'b0;
    sample_rate_select_i <= 3'h1;
    video_frame_rate_i <= 3'h1;
    wr(REG_MULT, 16'h000B);
    measure(3125);
    check("192fs blocked", edges[0], 16'h0000);
    wr(REG_WINDOW, 16'h0220);
    for (int m = 0; m < 7; m++)
    begin
      wr(REG_MULT, 16'h0008 | 16'(m));
      measure(1562);
      near("first multiple", edges[0], 16'(mul[m]), 16'(mul[m] / 64 + 2));
    end
    @(posedge clk_sys_i);
    sample_rate_select_i <= SEL_96K;
    wr(REG_MULT, 16'h0180);
    measure(3125);
    near("512fs third duty", high_cnt, 16'd1042, 16'd60);
    @(posedge clk_sys_i);
    sample_rate_select_i <= 3'h1;
    $display("multiple test done");
    wr(REG_MULT, 16'h000C);
    measure(6250);
    check("frame sync per frame", afs_cnt, 16'h0002);
    @(posedge clk_sys_i);
    sample_rate_select_i <= 3'h3;
    video_frame_rate_i <= FR_2997;
    repeat (3125) @(posedge clk_sys_i);
    measure(15625);
    check("five frame sequence", afs_cnt, 16'h0001);
    check("ten field marker", tfm_cnt, 16'h0001);
    wait_afs(f0);
    wr(REG_RESYNC, 16'h0001);
    wait_afs(rd);
    check("host resync frame", rd, f0 + 16'h1);
    @(posedge clk_sys_i);
    field_id_ignore_i <= 1'b1;
    fid_frame <= rd + 16'h3;
    fid_en <= 1'b1;
    wait_afs(f0);
    check("field id ignored", f0, rd + 16'h5);
    @(posedge clk_sys_i);
    field_id_ignore_i <= 1'b0;
    fid_frame <= f0 + 16'h2;
    wait_afs(rd);
    check("field id resync", rd, f0 + 16'h2);
    $display("frame test done");
    results();
  end
endmodule
